// ==== hw/tcirq_aux_if.sv ====
// Interface: pin configuration and trigger between register bank and pin trigger unit
`timescale 1ns/1ps
interface tcirq_aux_if;
  tcirq_pkg::tcirq_pin_func_t func;
  tcirq_pkg::tcirq_trig_t     trig_type;
  logic                       trig;

  modport ctl (output func, output trig_type, input trig);
  modport trg (input func, input trig_type, output trig);
endinterface

// ==== hw/tcirq_aux_trig.sv ====
// Module: synchroniser and trigger detection for the general-purpose pin input
`timescale 1ns/1ps
module tcirq_aux_trig (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   aux_pin_in,
  tcirq_aux_if.trg    aux
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic trig;
  } tcirq_trig_state_t;

  tcirq_trig_state_t s;
  tcirq_trig_state_t next_s;

  // ------------------------------------------------------------
  // Trigger decode
  // ------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.sync1 = aux_pin_in;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    next_s.trig  = 1'b0;
    if (aux.func == tcirq_pkg::TCIRQ_PIN_INPUT) begin
      case (aux.trig_type)
        tcirq_pkg::TCIRQ_TRIG_NEG_LEVEL: next_s.trig = !s.sync2;
        tcirq_pkg::TCIRQ_TRIG_POS_EDGE:  next_s.trig = s.sync2 && !s.prev;
        tcirq_pkg::TCIRQ_TRIG_NEG_EDGE:  next_s.trig = !s.sync2 && s.prev;
        tcirq_pkg::TCIRQ_TRIG_POS_LEVEL: next_s.trig = s.sync2;
        default:                         next_s.trig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign aux.trig = s.trig;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pos_edge_trig_a: assert property (
    (aux.func == tcirq_pkg::TCIRQ_PIN_INPUT && aux.trig_type == tcirq_pkg::TCIRQ_TRIG_POS_EDGE
     && s.sync2 && !s.prev) |=> aux.trig)
    else $error("positive edge did not trigger");

  pin_off_quiet_a: assert property (
    (aux.func != tcirq_pkg::TCIRQ_PIN_INPUT) |=> !aux.trig)
    else $error("trigger while pin not an input");

endmodule

// ==== hw/tcirq_pkg.sv ====
// Package: register map, field positions, reset values and constants of the touch config block
package tcirq_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_AMB_COMP_CTRL  = 10'h002;
  localparam logic [9:0] IDX_PROX_LEVEL     = 10'h003;
  localparam logic [9:0] IDX_PROX_RECAL     = 10'h004;
  localparam logic [9:0] IDX_LOW_EVENT_PIN  = 10'h005;
  localparam logic [9:0] IDX_INT_STATUS     = 10'h008;
  localparam logic [9:0] IDX_INT_MASK       = 10'h009;
  localparam logic [9:0] IDX_AUX_OUT_LEVEL  = 10'h00a;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_AMB_COMP_CTRL = 16'h0ff0;
  localparam logic [15:0] RST_PROX_LEVEL    = 16'h0164;
  localparam logic [15:0] RST_PROX_RECAL    = 16'hffff;
  localparam logic [15:0] RST_LOW_EVENT_PIN = 16'h0000;
  localparam logic [12:0] RST_INT_MASK      = 13'h0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SKIP_LSB      = 0;
  localparam int FP_HOLD_LSB   = 4;
  localparam int LP_HOLD_LSB   = 8;
  localparam int TIMEOUT_LSB   = 12;
  localparam int FORCE_CAL_BIT = 14;
  localparam int RESTART_BIT   = 15;
  localparam int FP_RECAL_LSB  = 0;
  localparam int LP_RECAL_LSB  = 10;
  localparam int RECAL_LVL_LSB = 0;
  localparam int DET_RATE_LSB  = 8;
  localparam int SLOW_UPD_LSB  = 14;
  localparam int AUX_FUNC_LSB  = 12;
  localparam int AUX_TRIG_LSB  = 14;
  localparam int NUM_STAGES    = 12;
  localparam int AUX_EVENT_BIT = 12;

  // ------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------
  localparam logic [3:0] SKIP_MAX       = 4'hb;
  localparam logic [4:0] FP_HOLD_MULT   = 5'h10;
  localparam logic [4:0] LP_HOLD_MULT   = 5'h04;
  // Timeout factors in sixteenths of one hold unit of 16 sequences
  localparam logic [5:0] TMO_FACTOR_00  = 6'h14;
  localparam logic [5:0] TMO_FACTOR_01  = 6'h18;
  localparam logic [5:0] TMO_FACTOR_10  = 6'h1c;
  localparam logic [5:0] TMO_FACTOR_11  = 6'h20;

  // ------------------------------------------------------------
  // Pin modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TCIRQ_PIN_OFF      = 2'b00,
    TCIRQ_PIN_INPUT    = 2'b01,
    TCIRQ_PIN_OUT_LOW  = 2'b10,
    TCIRQ_PIN_OUT_HIGH = 2'b11
  } tcirq_pin_func_t;

  typedef enum logic [1:0] {
    TCIRQ_TRIG_NEG_LEVEL = 2'b00,
    TCIRQ_TRIG_POS_EDGE  = 2'b01,
    TCIRQ_TRIG_NEG_EDGE  = 2'b10,
    TCIRQ_TRIG_POS_LEVEL = 2'b11
  } tcirq_trig_t;

endpackage

// ==== hw/tcirq_regs.sv ====
// Module: compensation, interrupt and pin configuration register bank with APB slave
//
// Functional notes
// - Admit one sequence result to fast FIFO after skipping skip-count sequences.
// - Full power: hold calibration off for count times 16 sequences.
// - Low power: hold calibration off for count times 4 sequences.
// - Enter low power after full-power count times 1.25/1.50/1.75/2.00.
// - Force-recalibrate bit set makes every stage recalibrate; zero is normal.
// - Writing restart bit returns sequence to first stage; bit self-clears.
// - Full-power proximity recalibration time is 10-bit field, reset 3FF.
// - Low-power proximity recalibration time is 6-bit field, reset 3F.
// - Per-stage low-event enable lets that stage assert the interrupt.
// - Pin function: off, input, active-low output, active-high output.
// - Input trigger: negative level, positive edge, negative edge, positive level.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module tcirq_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        seq_done,
  input  wire logic        prox_active,
  input  wire logic [11:0] stage_low_exceed,
  input  wire logic        aux_pin_in,
  output logic             aux_pin_out,
  output logic             aux_pin_oe_n,
  output logic             interrupt_out_n,
  output logic             fast_fifo_admit,
  output logic             cal_suspend,
  output logic             low_power_mode,
  output logic             force_recalibrate,
  output logic             sequence_restart,
  output logic      [9:0]  full_power_prox_recal_time,
  output logic      [5:0]  low_power_prox_recal_time,
  output logic      [7:0]  prox_recal_level,
  output logic      [5:0]  prox_detect_rate,
  output logic      [1:0]  slow_filter_update_level
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] amb_ctrl;
    logic [15:0] prox_level;
    logic [15:0] prox_recal;
    logic [15:0] low_pin;
    logic [12:0] int_stat;
    logic [12:0] int_mask;
    logic        aux_level;
    logic [3:0]  skip_cnt;
    logic        admit;
    logic [7:0]  hold;
    logic        cal_suspend;
    logic [9:0]  idle;
    logic        low_power;
    logic        restart;
    logic        irq_n;
    logic        aux_out;
    logic        aux_oe_n;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tcirq_state_t;

  tcirq_state_t s;
  tcirq_state_t next_s;

  tcirq_aux_if aux ();

  tcirq_aux_trig u_aux_trig (
    .pclk       (pclk),
    .presetn    (presetn),
    .aux_pin_in (aux_pin_in),
    .aux        (aux.trg)
  );

  // ------------------------------------------------------------
  // Field views
  // ------------------------------------------------------------
  logic [3:0]  skip_code;
  logic [3:0]  fp_count;
  logic [3:0]  lp_count;
  logic [1:0]  tmo_code;
  logic [5:0]  tmo_factor;
  logic [9:0]  tmo_limit;
  logic [9:0]  bus_idx;
  logic        access;
  logic        wr;
  logic [12:0] event_set;
  logic [12:0] src_enable;

  assign skip_code = s.amb_ctrl[tcirq_pkg::SKIP_LSB +: 4];
  assign fp_count  = s.amb_ctrl[tcirq_pkg::FP_HOLD_LSB +: 4];
  assign lp_count  = s.amb_ctrl[tcirq_pkg::LP_HOLD_LSB +: 4];
  assign tmo_code  = s.amb_ctrl[tcirq_pkg::TIMEOUT_LSB +: 2];
  assign bus_idx   = paddr[11:2];
  assign access    = psel && penable && !s.pready;
  assign wr        = psel && penable && s.pready && pwrite;

  always_comb begin
    case (tmo_code)
      2'b00:   tmo_factor = tcirq_pkg::TMO_FACTOR_00;
      2'b01:   tmo_factor = tcirq_pkg::TMO_FACTOR_01;
      2'b10:   tmo_factor = tcirq_pkg::TMO_FACTOR_10;
      default: tmo_factor = tcirq_pkg::TMO_FACTOR_11;
    endcase
  end

  assign tmo_limit = 10'(fp_count) * 10'(tmo_factor);

  assign aux.func      = tcirq_pkg::tcirq_pin_func_t'(s.low_pin[tcirq_pkg::AUX_FUNC_LSB +: 2]);
  assign aux.trig_type = tcirq_pkg::tcirq_trig_t'(s.low_pin[tcirq_pkg::AUX_TRIG_LSB +: 2]);

  // Stage enables gate stage events; the pin event is gated by its own input mode
  assign src_enable = {1'b1, s.low_pin[tcirq_pkg::NUM_STAGES-1:0]};

  generate
    for (genvar i = 0; i < tcirq_pkg::NUM_STAGES; i++) begin : g_stage
      assign event_set[i] = stage_low_exceed[i] && s.low_pin[i];
    end
  endgenerate
  assign event_set[tcirq_pkg::AUX_EVENT_BIT] = aux.trig;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.admit   = 1'b0;
    next_s.restart = 1'b0;
    next_s.pready  = access;

    // Bus read and error answer
    if (access) begin
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      case (bus_idx)
        tcirq_pkg::IDX_AMB_COMP_CTRL: next_s.prdata[15:0] = s.amb_ctrl;
        tcirq_pkg::IDX_PROX_LEVEL:    next_s.prdata[15:0] = s.prox_level;
        tcirq_pkg::IDX_PROX_RECAL:    next_s.prdata[15:0] = s.prox_recal;
        tcirq_pkg::IDX_LOW_EVENT_PIN: next_s.prdata[15:0] = s.low_pin;
        tcirq_pkg::IDX_INT_STATUS:    next_s.prdata[12:0] = s.int_stat;
        tcirq_pkg::IDX_INT_MASK:      next_s.prdata[12:0] = s.int_mask;
        tcirq_pkg::IDX_AUX_OUT_LEVEL: next_s.prdata[0]    = s.aux_level;
        default:                      next_s.pslverr      = 1'b1;
      endcase
    end

    // Register writes
    if (wr) begin
      case (bus_idx)
        tcirq_pkg::IDX_AMB_COMP_CTRL: begin
          next_s.amb_ctrl = {1'b0, pwdata[14:0]};
          if (pwdata[3:0] > tcirq_pkg::SKIP_MAX) begin
            next_s.amb_ctrl[tcirq_pkg::SKIP_LSB +: 4] = tcirq_pkg::SKIP_MAX;
          end
          next_s.restart = pwdata[tcirq_pkg::RESTART_BIT];
        end
        tcirq_pkg::IDX_PROX_LEVEL:    next_s.prox_level = pwdata[15:0];
        tcirq_pkg::IDX_PROX_RECAL:    next_s.prox_recal = pwdata[15:0];
        tcirq_pkg::IDX_LOW_EVENT_PIN: next_s.low_pin    = pwdata[15:0];
        tcirq_pkg::IDX_INT_STATUS:    next_s.int_stat   = s.int_stat & ~pwdata[12:0];
        tcirq_pkg::IDX_INT_MASK:      next_s.int_mask   = pwdata[12:0];
        tcirq_pkg::IDX_AUX_OUT_LEVEL: next_s.aux_level  = pwdata[0];
        default: begin
        end
      endcase
    end

    // Sticky events, set wins over clear
    next_s.int_stat = next_s.int_stat | event_set;

    // Fast FIFO decimation
    if (s.restart) begin
      next_s.skip_cnt = 4'h0;
    end else if (seq_done) begin
      if (s.skip_cnt >= skip_code) begin
        next_s.admit    = 1'b1;
        next_s.skip_cnt = 4'h0;
      end else begin
        next_s.skip_cnt = s.skip_cnt + 4'h1;
      end
    end

    // Calibration hold-off
    if (prox_active) begin
      if (s.low_power) begin
        next_s.hold = 8'(lp_count) * 8'(tcirq_pkg::LP_HOLD_MULT);
      end else begin
        next_s.hold = 8'(fp_count) * 8'(tcirq_pkg::FP_HOLD_MULT);
      end
    end else if (seq_done && s.hold != 8'h00) begin
      next_s.hold = s.hold - 8'h01;
    end
    next_s.cal_suspend = prox_active || (next_s.hold != 8'h00);

    // Power mode
    if (prox_active) begin
      next_s.low_power = 1'b0;
      next_s.idle      = 10'h000;
    end else if (seq_done && !s.low_power) begin
      if (s.idle + 10'h001 >= tmo_limit) begin
        next_s.low_power = 1'b1;
        next_s.idle      = 10'h000;
      end else begin
        next_s.idle = s.idle + 10'h001;
      end
    end

    // Interrupt output
    next_s.irq_n = ~|(next_s.int_stat & next_s.int_mask & {1'b1, next_s.low_pin[tcirq_pkg::NUM_STAGES-1:0]});

    // Pin drive
    case (aux.func)
      tcirq_pkg::TCIRQ_PIN_OUT_LOW: begin
        next_s.aux_out  = !s.aux_level;
        next_s.aux_oe_n = 1'b0;
      end
      tcirq_pkg::TCIRQ_PIN_OUT_HIGH: begin
        next_s.aux_out  = s.aux_level;
        next_s.aux_oe_n = 1'b0;
      end
      default: begin
        next_s.aux_out  = 1'b0;
        next_s.aux_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.amb_ctrl   <= tcirq_pkg::RST_AMB_COMP_CTRL;
      s.prox_level <= tcirq_pkg::RST_PROX_LEVEL;
      s.prox_recal <= tcirq_pkg::RST_PROX_RECAL;
      s.low_pin    <= tcirq_pkg::RST_LOW_EVENT_PIN;
      s.int_mask   <= tcirq_pkg::RST_INT_MASK;
      s.irq_n      <= 1'b1;
      s.aux_oe_n   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata                     = s.prdata;
  assign pready                     = s.pready;
  assign pslverr                    = s.pslverr;
  assign aux_pin_out                = s.aux_out;
  assign aux_pin_oe_n               = s.aux_oe_n;
  assign interrupt_out_n            = s.irq_n;
  assign fast_fifo_admit            = s.admit;
  assign cal_suspend                = s.cal_suspend;
  assign low_power_mode             = s.low_power;
  assign force_recalibrate          = s.amb_ctrl[tcirq_pkg::FORCE_CAL_BIT];
  assign sequence_restart           = s.restart;
  assign full_power_prox_recal_time = s.prox_recal[tcirq_pkg::FP_RECAL_LSB +: 10];
  assign low_power_prox_recal_time  = s.prox_recal[tcirq_pkg::LP_RECAL_LSB +: 6];
  assign prox_recal_level           = s.prox_level[tcirq_pkg::RECAL_LVL_LSB +: 8];
  assign prox_detect_rate           = s.prox_level[tcirq_pkg::DET_RATE_LSB +: 6];
  assign slow_filter_update_level   = s.prox_level[tcirq_pkg::SLOW_UPD_LSB +: 2];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctrl_write_s;
    wr && bus_idx == tcirq_pkg::IDX_AMB_COMP_CTRL;
  endsequence

  sequence restart_write_s;
    ctrl_write_s ##0 pwdata[tcirq_pkg::RESTART_BIT];
  endsequence

  restart_pulse_a: assert property (
    restart_write_s |=> sequence_restart ##1 !sequence_restart)
    else $error("restart pulse not one cycle");

  restart_clear_a: assert property (
    ctrl_write_s |=> !s.amb_ctrl[tcirq_pkg::RESTART_BIT])
    else $error("restart bit did not clear");

  force_cal_a: assert property (
    ctrl_write_s |=> force_recalibrate == $past(pwdata[tcirq_pkg::FORCE_CAL_BIT]))
    else $error("force recalibrate not taken");

  skip_admit_a: assert property (
    (seq_done && !s.restart && s.skip_cnt >= skip_code) |=> fast_fifo_admit && s.skip_cnt == 4'h0)
    else $error("sequence not admitted");

  skip_drop_a: assert property (
    (seq_done && !s.restart && s.skip_cnt < skip_code) |=> !fast_fifo_admit)
    else $error("skipped sequence admitted");

  fp_hold_a: assert property (
    (prox_active && !s.low_power) |=> s.hold == 8'($past(fp_count)) * 8'h10 && cal_suspend)
    else $error("full power hold wrong");

  lp_hold_a: assert property (
    (prox_active && s.low_power) |=> s.hold == 8'($past(lp_count)) * 8'h04)
    else $error("low power hold wrong");

  lp_entry_a: assert property (
    (seq_done && !prox_active && !s.low_power && s.idle + 10'h001 >= tmo_limit) |=> low_power_mode)
    else $error("low power not entered");

  irq_level_a: assert property (
    (|(s.int_stat & s.int_mask & src_enable)) == !interrupt_out_n)
    else $error("interrupt level mismatch");

  stage_set_a: assert property (
    (stage_low_exceed[0] && s.low_pin[0]) |=> s.int_stat[0])
    else $error("enabled stage event lost");

  pin_off_a: assert property (
    (aux.func == tcirq_pkg::TCIRQ_PIN_OFF || aux.func == tcirq_pkg::TCIRQ_PIN_INPUT) |=> aux_pin_oe_n)
    else $error("pin driven while not output");

  recal_times_a: assert property (
    $rose(presetn) |-> full_power_prox_recal_time == 10'h3ff && low_power_prox_recal_time == 6'h3f)
    else $error("recal time reset wrong");

endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the touch configuration and interrupt register bank
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        seq_done;
  logic        prox_active;
  logic [11:0] stage_low_exceed;
  logic        aux_pin_in;
  logic        aux_pin_out;
  logic        aux_pin_oe_n;
  logic        interrupt_out_n;
  logic        fast_fifo_admit;
  logic        cal_suspend;
  logic        low_power_mode;
  logic        force_recalibrate;
  logic        sequence_restart;
  logic [9:0]  full_power_prox_recal_time;
  logic [5:0]  low_power_prox_recal_time;
  logic [7:0]  prox_recal_level;
  logic [5:0]  prox_detect_rate;
  logic [1:0]  slow_filter_update_level;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          n_compared;
  int          n_admit;
  int          n_restart;
  int          seed;
  localparam logic [11:0] A_CTRL = {tcirq_pkg::IDX_AMB_COMP_CTRL, 2'b00};
  localparam logic [11:0] A_LVL  = {tcirq_pkg::IDX_PROX_LEVEL, 2'b00};
  localparam logic [11:0] A_RCL  = {tcirq_pkg::IDX_PROX_RECAL, 2'b00};
  localparam logic [11:0] A_PIN  = {tcirq_pkg::IDX_LOW_EVENT_PIN, 2'b00};
  localparam logic [11:0] A_ST   = {tcirq_pkg::IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] A_MSK  = {tcirq_pkg::IDX_INT_MASK, 2'b00};
  localparam logic [11:0] A_AOUT = {tcirq_pkg::IDX_AUX_OUT_LEVEL, 2'b00};

  tcirq_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .seq_done, .prox_active, .stage_low_exceed, .aux_pin_in, .aux_pin_out, .aux_pin_oe_n, .interrupt_out_n,
    .fast_fifo_admit, .cal_suspend, .low_power_mode, .force_recalibrate, .sequence_restart,
    .full_power_prox_recal_time, .low_power_prox_recal_time, .prox_recal_level, .prox_detect_rate,
    .slow_filter_update_level);

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (fast_fifo_admit === 1'b1) n_admit++;
    if (sequence_restart === 1'b1) n_restart++;
  end

  function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
    logic [31:0] r;
    r = w & 32'h0000_7fff;
    if (r[3:0] > 4'hb) r[3:0] = 4'hb;
    return r;
  endfunction

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic seq(input int n);
    repeat (n) begin
      @(posedge pclk);
      seq_done <= 1'b1;
      @(posedge pclk);
      seq_done <= 1'b0;
    end
    cyc(2);
  endtask

  task automatic pulse_ev(input logic [11:0] ev);
    @(posedge pclk);
    stage_low_exceed <= ev;
    @(posedge pclk);
    stage_low_exceed <= 12'h000;
    cyc(3);
  endtask

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial begin
    #300000;
    miscompares++;
    wrap_up();
  end

  initial begin
    logic [31:0] w;
    logic [31:0] en;
    logic [31:0] ev;
    logic        lv;
    logic        p0;
    int          nb;
    int          k;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seq_done = 1'b0;
    prox_active = 1'b0;
    stage_low_exceed = 12'h000;
    aux_pin_in = 1'b0;
    miscompares = 0;
    n_compared = 0;
    n_admit = 0;
    n_restart = 0;
    seed = 32'h2986;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_CTRL, 32'h0ff0, "ctrl reset");
    rdchk(A_LVL, 32'h0164, "level reset");
    chk("recal level", prox_recal_level, 32'h64);
    chk("detect rate", prox_detect_rate, 32'h1);
    chk("slow update", slow_filter_update_level, 32'h0);
    rdchk(A_RCL, 32'hffff, "recal reset");
    chk("fp recal time", full_power_prox_recal_time, 32'h3ff);
    chk("lp recal time", low_power_prox_recal_time, 32'h3f);
    rdchk(A_PIN, 32'h0, "pin reset");
    chk("int idle", interrupt_out_n, 32'h1);
    apb(1'b0, 12'h03c, 32'h0);
    chk("unmapped error", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("reset and map test done");
    for (int i = 0; i < 6; i++) begin
      w = $random(seed) & 32'hffff_7fff;
      if (i == 0) w[3:0] = 4'hf;
      apb(1'b1, A_CTRL, w);
      rdchk(A_CTRL, exp_ctrl(w), "ctrl readback");
      chk("force recal", force_recalibrate, w[14]);
      w = $random(seed);
      apb(1'b1, A_RCL, w);
      rdchk(A_RCL, w & 32'hffff, "recal readback");
      chk("fp time", full_power_prox_recal_time, w[9:0]);
      chk("lp time", low_power_prox_recal_time, w[15:10]);
      w = $random(seed);
      apb(1'b1, A_LVL, w);
      rdchk(A_LVL, w & 32'hffff, "level readback");
      chk("recal level wr", prox_recal_level, w[7:0]);
      chk("detect rate wr", prox_detect_rate, w[13:8]);
      chk("slow update wr", slow_filter_update_level, w[15:14]);
    end
    $display("register access test done");
    nb = n_restart;
    apb(1'b1, A_CTRL, 32'h8000);
    cyc(3);
    chk("restart pulses", n_restart - nb, 32'h1);
    rdchk(A_CTRL, 32'h0, "restart self clear");
    chk("force recal off", force_recalibrate, 32'h0);
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 0 : ((i == 1) ? 2 : 15);
      apb(1'b1, A_CTRL, 32'h8000 | k);
      cyc(2);
      nb = n_admit;
      if (k > 11) k = 11;
      seq(3 * (k + 1));
      chk("admitted count", n_admit - nb, 32'h3);
    end
    $display("restart and skip test done");
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, A_CTRL, (t << 12) | 32'h0110);
      @(posedge pclk);
      prox_active <= 1'b1;
      cyc(2);
      prox_active <= 1'b0;
      cyc(2);
      seq(15);
      chk("hold active", cal_suspend, 32'h1);
      seq(1);
      chk("hold over", cal_suspend, 32'h0);
      seq(20 + 4 * t - 17);
      chk("still full power", low_power_mode, 32'h0);
      seq(1);
      chk("low power entry", low_power_mode, 32'h1);
    end
    $display("hold and timeout test done");
    apb(1'b1, A_MSK, 32'h1fff);
    for (int i = 0; i < 5; i++) begin
      en = (i == 0) ? 32'hfff : ($random(seed) & 32'hfff);
      ev = (i == 1) ? 32'h800 : ($random(seed) & 32'hfff);
      apb(1'b1, A_PIN, en);
      pulse_ev(ev[11:0]);
      rdchk(A_ST, ev & en, "low event status");
      chk("int level", interrupt_out_n, ((ev & en) == 0));
      apb(1'b1, A_ST, 32'h1fff);
      cyc(2);
      chk("int cleared", interrupt_out_n, 32'h1);
    end
    apb(1'b1, A_PIN, 32'hfff);
    apb(1'b1, A_MSK, 32'h0);
    pulse_ev(12'hfff);
    chk("int masked", interrupt_out_n, 32'h1);
    rdchk(A_ST, 32'hfff, "masked status");
    apb(1'b1, A_ST, 32'h1fff);
    $display("interrupt test done");
    lv = 1'($random(seed));
    apb(1'b1, A_AOUT, lv);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, A_PIN, f << 12);
      cyc(2);
      chk("pin enable", aux_pin_oe_n, (f < 2));
      if (f >= 2) chk("pin level", aux_pin_out, (f == 2) ? !lv : lv);
    end
    $display("pin output test done");
    apb(1'b1, A_MSK, 32'h1000);
    for (int m = 0; m < 4; m++) begin
      p0 = (m == 0 || m == 2);
      aux_pin_in <= p0;
      apb(1'b1, A_PIN, (m << 14) | 32'h1000);
      cyc(6);
      apb(1'b1, A_ST, 32'h1000);
      cyc(2);
      rdchk(A_ST, 32'h0, "no trigger");
      aux_pin_in <= ~p0;
      cyc(6);
      rdchk(A_ST, 32'h1000, "trigger");
      chk("pin int", interrupt_out_n, 32'h0);
    end
    $display("pin trigger test done");
    wrap_up();
  end
endmodule
